// File: serial_config_port_pkg.sv
// Constants and carrier types for the serial configuration port.
`default_nettype none

package serial_config_port_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SOFT_RESET_MS    = 5;
  localparam int unsigned RECOVER_CYCLES   = SOFT_RESET_MS * 1000 * CLK_MHZ;
  localparam int unsigned CS_IDLE_US       = 10;
  localparam int unsigned CS_IDLE_CYCLES   = CS_IDLE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 20;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned ADDR_W           = 15;
  localparam int unsigned DATA_W           = 8;
  localparam logic [4:0]  POS_RW           = 5'h00;
  localparam logic [4:0]  POS_ADDR_LAST    = 5'h0F;
  localparam logic [4:0]  POS_INSTR_SPLIT  = 5'h07;
  localparam logic [4:0]  POS_DATA_FIRST   = 5'h10;
  localparam logic [4:0]  POS_DATA_LAST    = 5'h17;
  localparam logic        READ_FLAG        = 1'b1;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [14:0] ADDR_IFACE_CFG   = 15'h0000;
  localparam logic [14:0] ADDR_SAMPLE_FMT  = 15'h0561;
  localparam logic [14:0] ADDR_LINK_SYNC   = 15'h0572;
  localparam logic [14:0] ADDR_LINK_TEST   = 15'h0574;
  localparam logic [14:0] IFACE_LO         = 15'h0000;
  localparam logic [14:0] IFACE_HI         = 15'h000F;
  localparam logic [14:0] OUTPUT_LO        = 15'h0550;
  localparam logic [14:0] OUTPUT_HI        = 15'h05CB;

  localparam int unsigned CFG_RST_MIRROR   = 7;
  localparam int unsigned CFG_LSB_MIRROR   = 6;
  localparam int unsigned CFG_ASC_MIRROR   = 5;
  localparam int unsigned CFG_ASC          = 2;
  localparam int unsigned CFG_LSB          = 1;
  localparam int unsigned CFG_RST          = 0;
  localparam logic [7:0]  CFG_WR_MASK      = 8'h66;
  localparam logic [7:0]  TEST_SEL_MASK    = 8'h07;

  localparam logic [7:0]  IFACE_CFG_RST    = 8'h00;
  localparam logic [7:0]  SAMPLE_FMT_RST   = 8'h01;
  localparam logic [7:0]  LINK_SYNC_RST    = 8'h00;
  localparam logic [7:0]  LINK_TEST_RST    = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] iface_cfg;
    logic [7:0] sample_fmt;
    logic [7:0] link_sync;
    logic [7:0] link_test;
  } reg_snap_t;

  localparam reg_snap_t SNAP_RST = '{IFACE_CFG_RST, SAMPLE_FMT_RST, LINK_SYNC_RST, LINK_TEST_RST};

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } wr_word_t;

endpackage : serial_config_port_pkg

`default_nettype wire

// File: serial_config_port.sv
// Three-wire serial configuration port with its register file.
//
// Operation
// - Chip select is active low; accesses happen only while it is low.
// - A frame starts on the first rising serial clock after chip select falls.
// - Chip select held low keeps streaming successive data bytes.
// - Chip select may rise after the first instruction byte without losing frame position; any other rise starts a new frame.
// - Chip select held high tristates the data pin and enables secondary functions.
// - Every data unit is an eight-bit byte; each address holds one byte.
// - The first instruction bit selects read or write.
// - Reads turn the data pin to output in the data phase; writes never.
// - Bits shift MSB first after reset; software may choose LSB first.
// - Writing 0x81 to address 0x0000 soft-resets; host waits 5 ms.
// - Any reset reloads the configuration registers with defaults.
// - Output sample format register 0x0561 resets to 0x01.
// - Bits 2 to 0 of register 0x0574 select the link test pattern.
// - Addresses 0x0000-0x000F and 0x0550-0x05CB are decoded.
// - Bit 6 or mirror bit 1 selects LSB first shifting.
// - Bit 5 or mirror bit 2 selects address increment, else decrement.
// - Bit 7 or mirror bit 0 resets port and registers, then self-clears.
`default_nettype none

module serial_config_port #(
  parameter int unsigned P_RECOVER_CYCLES = serial_config_port_pkg::RECOVER_CYCLES
) (
  // System clock domain
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  // Serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_sdio,
  output logic            o_sdio,
  output logic            o_sdio_oe,
  // Configuration towards the converter
  output logic [7:0]      o_sample_format,
  output logic [7:0]      o_link_sync_control,
  output logic [2:0]      o_link_test_select,
  output logic            o_secondary_en,
  output logic            o_recovering
);

  // ****************************************************************
  // Shared decode
  // ****************************************************************
  function automatic logic in_map(input logic [14:0] a);
    in_map = (a <= serial_config_port_pkg::IFACE_HI) ||
             (a >= serial_config_port_pkg::OUTPUT_LO && a <= serial_config_port_pkg::OUTPUT_HI);
  endfunction : in_map

  function automatic logic [7:0] rd_byte(input logic [14:0] a, input serial_config_port_pkg::reg_snap_t s);
    rd_byte = 8'h00;
    if (in_map(a)) begin
      case (a)
        serial_config_port_pkg::ADDR_IFACE_CFG:  rd_byte = s.iface_cfg;
        serial_config_port_pkg::ADDR_SAMPLE_FMT: rd_byte = s.sample_fmt;
        serial_config_port_pkg::ADDR_LINK_SYNC:  rd_byte = s.link_sync;
        serial_config_port_pkg::ADDR_LINK_TEST:  rd_byte = s.link_test;
        default:                                 rd_byte = 8'h00;
      endcase
    end
  endfunction : rd_byte

  // ****************************************************************
  // Serial clock domain
  // ****************************************************************
  // Frame state is cleared asynchronously by chip select high, because the
  // host stops the serial clock outside frames and no edge would clear it.
  logic                                gap_r;
  logic                                stall_ok_r;
  logic [4:0]                          pos_r;
  logic                                rw_r;
  logic [14:0]                         addr_r;
  logic [7:0]                          shift_r;
  serial_config_port_pkg::wr_word_t    wr_word_r;
  logic                                wr_tgl_r;
  serial_config_port_pkg::reg_snap_t   cfg_copy_r;
  logic                                snap_s1_r;
  logic                                snap_s2_r;
  logic                                snap_s3_r;
  logic                                lsb_first;
  logic                                ascend;
  logic                                start;
  logic [4:0]                          pos_now;
  logic [7:0]                          byte_in;
  logic [7:0]                          rd_now;
  serial_config_port_pkg::reg_snap_t   snap_r;
  logic                                snap_tgl_r;

  assign lsb_first = cfg_copy_r.iface_cfg[serial_config_port_pkg::CFG_LSB_MIRROR] |
                     cfg_copy_r.iface_cfg[serial_config_port_pkg::CFG_LSB];
  assign ascend    = cfg_copy_r.iface_cfg[serial_config_port_pkg::CFG_ASC_MIRROR] |
                     cfg_copy_r.iface_cfg[serial_config_port_pkg::CFG_ASC];
  // A gap after the first instruction byte is a stall; any other gap opens a new frame.
  assign start     = gap_r && !stall_ok_r;
  assign pos_now   = start ? serial_config_port_pkg::POS_RW : pos_r;
  assign rd_now    = rd_byte(addr_r, cfg_copy_r);
  assign byte_in   = lsb_first ? {i_sdio, shift_r[7:1]} : {shift_r[6:0], i_sdio};

  always_ff @(posedge i_sclk or posedge i_chip_select_n or posedge i_reset) begin
    if (i_chip_select_n || i_reset) begin
      gap_r <= 1'b1;
    end else begin
      gap_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      stall_ok_r <= 1'b0;
    end else if (!i_chip_select_n) begin
      stall_ok_r <= (pos_now == serial_config_port_pkg::POS_INSTR_SPLIT);
    end
  end

  always_ff @(posedge i_sclk) begin
    if (!i_chip_select_n) begin
      if (pos_now == serial_config_port_pkg::POS_RW) begin
        rw_r  <= i_sdio;
        pos_r <= pos_now + 5'h01;
      end else if (pos_now <= serial_config_port_pkg::POS_ADDR_LAST) begin
        if (lsb_first) begin
          addr_r[4'(pos_now - 5'h01)] <= i_sdio;
        end else begin
          addr_r[4'(serial_config_port_pkg::POS_ADDR_LAST - pos_now)] <= i_sdio;
        end
        pos_r <= pos_now + 5'h01;
      end else begin
        shift_r <= byte_in;
        if (pos_now == serial_config_port_pkg::POS_DATA_LAST) begin
          addr_r <= ascend ? addr_r + 15'h0001 : addr_r - 15'h0001;
          pos_r  <= serial_config_port_pkg::POS_DATA_FIRST;
        end else begin
          pos_r <= pos_now + 5'h01;
        end
      end
    end
  end

  // The toggle is reset so that the system side never sees an unknown write event.
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      wr_word_r <= '0;
      wr_tgl_r  <= 1'b0;
    end else if (!i_chip_select_n && pos_now == serial_config_port_pkg::POS_DATA_LAST &&
                 rw_r != serial_config_port_pkg::READ_FLAG) begin
      wr_word_r <= '{addr_r, byte_in};
      wr_tgl_r  <= ~wr_tgl_r;
    end
  end

  // The snapshot word is held still by the sender until the toggle is acknowledged.
  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      snap_s1_r  <= 1'b0;
      snap_s2_r  <= 1'b0;
      snap_s3_r  <= 1'b0;
      cfg_copy_r <= serial_config_port_pkg::SNAP_RST;
    end else begin
      snap_s1_r <= snap_tgl_r;
      snap_s2_r <= snap_s1_r;
      snap_s3_r <= snap_s2_r;
      if (snap_s2_r != snap_s3_r) begin
        cfg_copy_r <= snap_r;
      end
    end
  end

  // Readback leaves on the falling edge so the host samples it on the next rise.
  always_ff @(negedge i_sclk or posedge i_chip_select_n or posedge i_reset) begin
    if (i_chip_select_n || i_reset) begin
      o_sdio_oe <= 1'b0;
      o_sdio    <= 1'b0;
    end else begin
      o_sdio_oe <= (rw_r == serial_config_port_pkg::READ_FLAG) &&
                   (pos_r >= serial_config_port_pkg::POS_DATA_FIRST);
      o_sdio    <= lsb_first ? rd_now[pos_r[2:0]] : rd_now[3'h7 - pos_r[2:0]];
    end
  end

  // ****************************************************************
  // System clock domain
  // ****************************************************************
  logic                                cs_s1_r;
  logic                                cs_s2_r;
  localparam int unsigned              CNT_BITS = serial_config_port_pkg::CNT_W;
  logic [CNT_BITS-1:0]                 idle_cnt_r;
  logic                                wt_s1_r;
  logic                                wt_s2_r;
  logic                                wt_s3_r;
  logic                                ak_s1_r;
  logic                                ak_s2_r;
  serial_config_port_pkg::reg_snap_t   regs_r;
  logic [CNT_BITS-1:0]                 rec_cnt_r;
  logic                                wr_evt;
  logic                                soft_rst;
  logic                                wr_ok;

  assign wr_evt   = wt_s2_r != wt_s3_r;
  assign soft_rst = wr_evt && !o_recovering && wr_word_r.addr == serial_config_port_pkg::ADDR_IFACE_CFG &&
                    (wr_word_r.data[serial_config_port_pkg::CFG_RST_MIRROR] |
                     wr_word_r.data[serial_config_port_pkg::CFG_RST]);
  assign wr_ok    = wr_evt && !o_recovering && in_map(wr_word_r.addr);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      wt_s1_r <= 1'b0;
      wt_s2_r <= 1'b0;
      wt_s3_r <= 1'b0;
      ak_s1_r <= 1'b0;
      ak_s2_r <= 1'b0;
    end else if (i_clk_en) begin
      cs_s1_r <= i_chip_select_n;
      cs_s2_r <= cs_s1_r;
      wt_s1_r <= wr_tgl_r;
      wt_s2_r <= wt_s1_r;
      wt_s3_r <= wt_s2_r;
      ak_s1_r <= snap_s2_r;
      ak_s2_r <= ak_s1_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      idle_cnt_r     <= '0;
      o_secondary_en <= 1'b0;
    end else if (i_clk_en) begin
      if (!cs_s2_r) begin
        idle_cnt_r     <= '0;
        o_secondary_en <= 1'b0;
      end else if (idle_cnt_r >= CNT_BITS'(serial_config_port_pkg::CS_IDLE_CYCLES - 1)) begin
        o_secondary_en <= 1'b1;
      end else begin
        idle_cnt_r <= idle_cnt_r + CNT_BITS'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || (i_clk_en && soft_rst)) begin
      regs_r <= serial_config_port_pkg::SNAP_RST;
    end else if (i_clk_en && wr_ok) begin
      case (wr_word_r.addr)
        serial_config_port_pkg::ADDR_IFACE_CFG:
          regs_r.iface_cfg <= wr_word_r.data & serial_config_port_pkg::CFG_WR_MASK;
        serial_config_port_pkg::ADDR_SAMPLE_FMT:
          regs_r.sample_fmt <= wr_word_r.data;
        serial_config_port_pkg::ADDR_LINK_SYNC:
          regs_r.link_sync <= wr_word_r.data;
        serial_config_port_pkg::ADDR_LINK_TEST:
          regs_r.link_test <= wr_word_r.data & serial_config_port_pkg::TEST_SEL_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rec_cnt_r    <= '0;
      o_recovering <= 1'b0;
    end else if (i_clk_en) begin
      if (soft_rst) begin
        rec_cnt_r    <= CNT_BITS'(P_RECOVER_CYCLES - 1);
        o_recovering <= 1'b1;
      end else if (rec_cnt_r != '0) begin
        rec_cnt_r <= rec_cnt_r - CNT_BITS'(1);
      end else begin
        o_recovering <= 1'b0;
      end
    end
  end

  // A new snapshot leaves only after the previous one was acknowledged.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      snap_r     <= serial_config_port_pkg::SNAP_RST;
      snap_tgl_r <= 1'b0;
    end else if (i_clk_en && ak_s2_r == snap_tgl_r && snap_r != regs_r) begin
      snap_r     <= regs_r;
      snap_tgl_r <= ~snap_tgl_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_sample_format     <= serial_config_port_pkg::SAMPLE_FMT_RST;
      o_link_sync_control <= serial_config_port_pkg::LINK_SYNC_RST;
      o_link_test_select  <= serial_config_port_pkg::LINK_TEST_RST[2:0];
    end else if (i_clk_en) begin
      o_sample_format     <= regs_r.sample_fmt;
      o_link_sync_control <= regs_r.link_sync;
      o_link_test_select  <= regs_r.link_test[2:0];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_soft_reset_write;
    soft_rst && i_clk_en;
  endsequence

  AST_SOFT_RESET_ENTERS_RECOVERY: assert property (
    s_soft_reset_write |=> o_recovering && rec_cnt_r == CNT_BITS'(P_RECOVER_CYCLES - 1))
    else $error("Soft reset write did not start recovery.");

  AST_SOFT_RESET_DEFAULTS: assert property (
    s_soft_reset_write |=> regs_r == serial_config_port_pkg::SNAP_RST)
    else $error("Soft reset did not reload defaults.");

  AST_SAMPLE_FORMAT_DEFAULT: assert property (
    $fell(i_reset) |-> o_sample_format == serial_config_port_pkg::SAMPLE_FMT_RST)
    else $error("Sample format not at default after reset.");

  AST_SELF_CLEAR: assert property (
    regs_r.iface_cfg[serial_config_port_pkg::CFG_RST] == 1'b0 &&
    regs_r.iface_cfg[serial_config_port_pkg::CFG_RST_MIRROR] == 1'b0)
    else $error("Reset bits did not self-clear.");

  AST_TEST_SELECT_FOLLOWS: assert property (
    (i_clk_en && wr_ok && !soft_rst && wr_word_r.addr == serial_config_port_pkg::ADDR_LINK_TEST)
    ##1 i_clk_en |=> o_link_test_select == $past(regs_r.link_test[2:0]))
    else $error("Test select output does not follow its register.");

  AST_UNMAPPED_NO_EFFECT: assert property (
    (i_clk_en && wr_evt && !in_map(wr_word_r.addr)) |=> $stable(regs_r))
    else $error("Write outside the map changed a register.");

  AST_SECONDARY_ON_IDLE: assert property (
    (cs_s2_r && i_clk_en && idle_cnt_r >= CNT_BITS'(serial_config_port_pkg::CS_IDLE_CYCLES - 1))
    |=> o_secondary_en)
    else $error("Secondary functions not enabled after idle chip select.");

  AST_SECONDARY_OFF_IN_FRAME: assert property (
    (!cs_s2_r && i_clk_en) |=> !o_secondary_en)
    else $error("Secondary functions enabled during a frame.");

  AST_RECOVERY_BLOCKS_WRITES: assert property (
    (o_recovering && i_clk_en && wr_evt) |=> $stable(regs_r))
    else $error("Register changed during soft reset recovery.");

  AST_READ_DRIVE_ONLY: assert property (@(negedge i_sclk) disable iff (i_chip_select_n)
    o_sdio_oe |-> rw_r == serial_config_port_pkg::READ_FLAG)
    else $error("Data pin driven during a write frame.");

endmodule : serial_config_port

`default_nettype wire

// File: serial_host_model.sv
// Behavioural serial host that frames register accesses on the three-wire port.
`default_nettype none

module serial_host_model (
  // Pins shared with the device
  input  wire logic       i_dev_sdio,
  input  wire logic       i_dev_oe,
  output var  logic       o_sclk,
  output var  logic       o_chip_select_n,
  output logic            o_pin,
  // Captured readback towards the bench
  output var  logic       o_rd_valid,
  output var  logic [7:0] o_rd_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_oe;
  logic drv_bit;
  logic junk;

  // The data line has no pull, so a released line wanders instead of holding its last bit.
  always #50 junk = ~junk;
  assign o_pin = i_dev_oe ? i_dev_sdio : (drv_oe ? drv_bit : junk);

  initial begin
    junk            = 1'b0;
    o_sclk          = 1'b0;
    o_chip_select_n = 1'b1;
    drv_oe          = 1'b0;
    drv_bit         = 1'b0;
    o_rd_valid      = 1'b0;
    o_rd_byte       = 8'h00;
  end

  // One serial clock period: data changes after the falling edge and is taken on the rising one.
  task automatic clock_bit(input logic b, input logic drive, output logic got);
    drv_oe = drive;
    if (drive) begin
      drv_bit = b;
    end
    #62.5 o_sclk = 1'b1;
    got = o_pin;
    #62.5 o_sclk = 1'b0;
  endtask : clock_bit

  task automatic xfer(input logic rd, input logic [14:0] addr, input int n, input logic [31:0] data,
                      input logic lsb, input logic stall);
    logic [7:0] byte_v;
    logic       got;
    o_chip_select_n = 1'b0;
    #40;
    clock_bit(rd, 1'b1, got);
    for (int i = 0; i < 15; i++) begin
      clock_bit(lsb ? addr[i] : addr[14-i], 1'b1, got);
      if (stall && i == 6) begin
        o_chip_select_n = 1'b1;
        #300 o_chip_select_n = 1'b0;
        #40;
      end
    end
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8; j++) begin
        clock_bit(data[8*k + (lsb ? j : 7-j)], !rd, got);
        byte_v[lsb ? j : 7-j] = got;
      end
      if (rd) begin
        o_rd_byte  = byte_v;
        o_rd_valid = 1'b1;
        #1 o_rd_valid = 1'b0;
      end
    end
    drv_oe = 1'b0;
    o_chip_select_n = 1'b1;
    #40;
  endtask : xfer

endmodule : serial_host_model

`default_nettype wire

// File: serial_config_port_tb.sv
// Self-checking bench for the serial configuration port driven by the host model.
`default_nettype none

module serial_config_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned RECOV = 50;

  // The clock starts high and reset rises at its first fall, so the link-side
  // asynchronous resets see a real edge.
  logic       clk_sys = 1'b1;
  logic       reset   = 1'b0;
  logic       clk_en  = 1'b1;
  logic       sclk;
  logic       chip_select_n;
  logic       pin;
  logic       dev_sdio;
  logic       dev_oe;
  logic [7:0] sample_format;
  logic [7:0] link_sync;
  logic [2:0] test_sel;
  logic       secondary_en;
  logic       recovering;
  logic       rd_valid;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  logic [7:0] r0;
  logic [7:0] r1;
  int         n;
  int         bad_count = 0;
  int         tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  serial_config_port #(.P_RECOVER_CYCLES(RECOV)) serial_config_port_inst (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(clk_en), .i_sclk(sclk),
    .i_chip_select_n(chip_select_n), .i_sdio(pin), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe),
    .o_sample_format(sample_format), .o_link_sync_control(link_sync), .o_link_test_select(test_sel),
    .o_secondary_en(secondary_en), .o_recovering(recovering));

  serial_host_model serial_host_model_inst (
    .i_dev_sdio(dev_sdio), .i_dev_oe(dev_oe), .o_sclk(sclk), .o_chip_select_n(chip_select_n),
    .o_pin(pin), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    if (exp_q.size() != 0) begin
      bad_count++;
    end
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic timed_out;
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    finish_test();
  endtask : timed_out

  // Readback bytes are matched against the oldest noted expectation.
  always @(posedge rd_valid) begin
    if (exp_q.size() == 0) begin
      bad_count++;
      $display("wrong value at %0t: unexpected readback", $time);
    end else begin
      check(rd_byte, exp_q.pop_front());
    end
  end

  initial begin
    #400us;
    timed_out();
  end

  // ****************************************************************
  // Host access helpers
  // ****************************************************************
  task automatic cycles(input int c);
    repeat (c) @(negedge clk_sys);
  endtask : cycles

  task automatic wr(input logic [14:0] a, input int nb, input logic [31:0] d, input logic lsb, input logic stall);
    serial_host_model_inst.xfer(1'b0, a, nb, d, lsb, stall);
    cycles(8);
  endtask : wr

  task automatic rd(input logic [14:0] a, input int nb, input logic [31:0] d, input logic lsb);
    for (int k = 0; k < nb; k++) begin
      exp_q.push_back(d[8*k +: 8]);
    end
    serial_host_model_inst.xfer(1'b1, a, nb, d, lsb, 1'b0);
    cycles(8);
  endtask : rd

  // An all-ones read outside the map returns zero in either bit order, so it lets a new
  // ordering settle on the link side without writing an unassigned location.
  task automatic dummy;
    rd(15'h7FFF, 1, 32'h0000_0000, 1'b0);
  endtask : dummy

  task automatic end_test(input string s);
    $display("test done: %s", s);
  endtask : end_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(23026));
    @(negedge clk_sys);
    reset = 1'b1;
    cycles(5);
    reset = 1'b0;
    cycles(10);
    check(sample_format, 8'h01);
    check(link_sync, 8'h00);
    check({5'h00, test_sel}, 8'h00);
    check({7'h00, dev_oe}, 8'h00);
    dummy();
    rd(15'h0561, 1, 32'h0000_0001, 1'b0);
    rd(15'h0000, 1, 32'h0000_0000, 1'b0);
    end_test("defaults");
    clk_en = 1'b0;
    wr(15'h0574, 1, 32'h0000_0003, 1'b0, 1'b0);
    check({5'h00, test_sel}, 8'h00);
    clk_en = 1'b1;
    cycles(8);
    check({5'h00, test_sel}, 8'h03);
    for (int v = 0; v < 8; v++) begin
      wr(15'h0574, 1, 32'(v), 1'b0, 1'b0);
      check({5'h00, test_sel}, 8'(v));
    end
    wr(15'h0572, 1, 32'h0000_00C0, 1'b0, 1'b0);
    check(link_sync, 8'hC0);
    end_test("link test select");
    r0 = 8'($urandom());
    r1 = 8'($urandom());
    wr(15'h0562, 2, {16'h0000, r1, r0}, 1'b0, 1'b0);
    check(sample_format, r1);
    r0 = 8'($urandom());
    wr(15'h0561, 1, {24'h000000, r0}, 1'b0, 1'b1);
    check(sample_format, r0);
    rd(15'h4561, 1, 32'h0000_0000, 1'b0);
    check(sample_format, r0);
    end_test("streaming, stall and decode");
    wr(15'h0000, 1, 32'h0000_0042, 1'b0, 1'b0);
    dummy();
    rd(15'h0000, 1, 32'h0000_0042, 1'b1);
    r1 = 8'($urandom());
    wr(15'h0561, 1, {24'h000000, r1}, 1'b1, 1'b0);
    check(sample_format, r1);
    dummy();
    rd(15'h0561, 1, {24'h000000, r1}, 1'b1);
    wr(15'h0000, 1, 32'h0000_0066, 1'b1, 1'b0);
    dummy();
    rd(15'h0572, 3, 32'h0007_00C0, 1'b1);
    end_test("bit order and ascending stream");
    wr(15'h0000, 1, 32'h0000_0081, 1'b1, 1'b0);
    check({7'h00, recovering}, 8'h01);
    check(sample_format, 8'h01);
    check(link_sync, 8'h00);
    check({5'h00, test_sel}, 8'h00);
    for (n = 0; n < 200 && recovering !== 1'b0; n++) begin
      cycles(1);
    end
    if (n == 200) begin
      timed_out();
    end
    dummy();
    rd(15'h0000, 1, 32'h0000_0000, 1'b0);
    end_test("soft reset");
    for (n = 0; n < 1100 && secondary_en !== 1'b1; n++) begin
      cycles(1);
    end
    check({7'h00, secondary_en}, 8'h01);
    check({7'h00, dev_oe}, 8'h00);
    end_test("idle chip select");
    finish_test();
  end

endmodule : serial_config_port_tb

`default_nettype wire
